// ### inc/dcl_defs.svh
`ifndef DCL_DEFS_SVH
`define DCL_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets (bus word addresses)
// ----------------------------------------------------------------
`define DCL_ADDR_CTRL0   4'h0
`define DCL_ADDR_CTRL1   4'h1
`define DCL_ADDR_STROBE  4'h2
`define DCL_ADDR_CODE    4'h3
`define DCL_ADDR_TRIM    4'h4
`define DCL_ADDR_ROUTE0  4'h5
`define DCL_ADDR_ROUTE2  4'h6
`define DCL_ADDR_ROUTE3  4'h7
`define DCL_ADDR_STATUS  4'h8
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCL_C0_MODE      4
`define DCL_C0_RANGE_HI  3
`define DCL_C0_RANGE_LO  2
`define DCL_C1_SRC       5
`define DCL_C1_RESET     4
`define DCL_C1_FAB_DIR   3
`define DCL_C1_DIR       2
`define DCL_ST_EN        3
`define DCL_ST_SEL_HI    2
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DCL_RST_BYTE     8'h00
`define DCL_RST_TRIM     8'h80
// ----------------------------------------------------------------
// Timing: converter update limits at 50 MHz
// ----------------------------------------------------------------
`define DCL_CLK_HZ       50000000
`define DCL_CURRENT_OUTPUT_MODE_SPS     8000000
`define DCL_VOLTAGE_OUTPUT_MODE_SPS     1000000
`define DCL_VDAC4_SPS    250000
`define DCL_CURRENT_OUTPUT_MODE_GAP     ((`DCL_CLK_HZ + `DCL_CURRENT_OUTPUT_MODE_SPS - 1) / `DCL_CURRENT_OUTPUT_MODE_SPS)
`define DCL_VOLTAGE_OUTPUT_MODE_GAP     ((`DCL_CLK_HZ + `DCL_VOLTAGE_OUTPUT_MODE_SPS - 1) / `DCL_VOLTAGE_OUTPUT_MODE_SPS)
`define DCL_VDAC4_GAP    ((`DCL_CLK_HZ + `DCL_VDAC4_SPS - 1) / `DCL_VDAC4_SPS)
`endif

// ### inc/dcl_pkg.sv
package dcl_pkg;
   // Strobe source selection
   typedef enum logic [2:0]
   {
      DCL_STB_BUS    = 3'b000,
      DCL_STB_ACLK0  = 3'b001,
      DCL_STB_ACLK1  = 3'b010,
      DCL_STB_ACLK2  = 3'b011,
      DCL_STB_ACLK3  = 3'b100,
      DCL_STB_FABRIC = 3'b101
   } dcl_stb_src_t;

   // Output mode
   typedef enum logic
   {
      DCL_MODE_VOLT = 1'b0,
      DCL_MODE_CURR = 1'b1
   } dcl_mode_t;

   // Analog-side control bundle
   typedef struct packed
   {
      logic [7:0] code;
      logic [7:0] trim;
      dcl_mode_t  mode;
      logic [1:0] range;
      logic       sink;
      logic       conv_reset;
      logic [7:0] route_vglob;
      logic [7:0] route_vloc;
      logic [7:0] route_mux;
   } dcl_analog_t;
endpackage

// ### design/dcl_control.sv
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "dcl_defs.svh"
module dcl_control
   import dcl_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic [7:0]  fab_code_i,
   input  wire logic        fab_strobe_i,
   input  wire logic        fab_sink_i,
   input  wire logic [3:0]  aclk_i,
   output dcl_analog_t      analog_o,
   output logic             update_o,
   output logic             rate_err_o
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl0_r, ctrl0_nxt;
   logic [7:0] ctrl1_r, ctrl1_nxt;
   logic [7:0] stb_r, stb_nxt;
   logic [7:0] code_r, code_nxt;
   logic [7:0] trim_r, trim_nxt;
   logic [7:0] rt0_r, rt0_nxt;
   logic [7:0] rt2_r, rt2_nxt;
   logic [7:0] rt3_r, rt3_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic       bus_wr_stb;

   // Read decode shared by the read port
   function automatic logic [7:0] rd_mux(input logic [3:0] a, input logic [7:0] st);
      case (a)
         `DCL_ADDR_CTRL0:  rd_mux = ctrl0_r;
         `DCL_ADDR_CTRL1:  rd_mux = ctrl1_r;
         `DCL_ADDR_STROBE: rd_mux = stb_r;
         `DCL_ADDR_CODE:   rd_mux = code_r;
         `DCL_ADDR_TRIM:   rd_mux = trim_r;
         `DCL_ADDR_ROUTE0: rd_mux = rt0_r;
         `DCL_ADDR_ROUTE2: rd_mux = rt2_r;
         `DCL_ADDR_ROUTE3: rd_mux = rt3_r;
         `DCL_ADDR_STATUS: rd_mux = st;
         default:          rd_mux = 8'h00;
      endcase
   endfunction

   // Register writes; unmapped addresses are ignored
   always_comb
   begin
      ctrl0_nxt = ctrl0_r;
      ctrl1_nxt = ctrl1_r;
      stb_nxt   = stb_r;
      code_nxt  = code_r;
      trim_nxt  = trim_r;
      rt0_nxt   = rt0_r;
      rt2_nxt   = rt2_r;
      rt3_nxt   = rt3_r;
      if (wr_i)
      begin
         case (addr_i)
            `DCL_ADDR_CTRL0:  ctrl0_nxt = wdata_i;
            `DCL_ADDR_CTRL1:  ctrl1_nxt = wdata_i;
            `DCL_ADDR_STROBE: stb_nxt   = wdata_i;
            `DCL_ADDR_CODE:   code_nxt  = wdata_i;
            `DCL_ADDR_TRIM:   trim_nxt  = wdata_i;
            `DCL_ADDR_ROUTE0: rt0_nxt   = wdata_i;
            `DCL_ADDR_ROUTE2: rt2_nxt   = wdata_i;
            `DCL_ADDR_ROUTE3: rt3_nxt   = wdata_i;
            default:          ;
         endcase
      end
   end

   // Bus write strobe: any write to the code register
   assign bus_wr_stb = wr_i && (addr_i == `DCL_ADDR_CODE);

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctrl0_r <= `DCL_RST_BYTE;
         ctrl1_r <= `DCL_RST_BYTE;
         stb_r   <= `DCL_RST_BYTE;
         code_r  <= `DCL_RST_BYTE;
         trim_r  <= `DCL_RST_TRIM;
         rt0_r   <= `DCL_RST_BYTE;
         rt2_r   <= `DCL_RST_BYTE;
         rt3_r   <= `DCL_RST_BYTE;
      end
      else
      begin
         ctrl0_r <= ctrl0_nxt;
         ctrl1_r <= ctrl1_nxt;
         stb_r   <= stb_nxt;
         code_r  <= code_nxt;
         trim_r  <= trim_nxt;
         rt0_r   <= rt0_nxt;
         rt2_r   <= rt2_nxt;
         rt3_r   <= rt3_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers for fabric and analog clock strobes
   // ----------------------------------------------------------------
   logic [5:0] sync1_r, sync2_r, sync3_r;
   logic [5:0] sync1_nxt;
   logic [7:0] fab1_r, fab2_r;

   // Only the second and third stages are read by logic
   assign sync1_nxt = {fab_sink_i, fab_strobe_i, aclk_i};

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
         sync3_r <= 6'h00;
         fab1_r  <= 8'h00;
         fab2_r  <= 8'h00;
      end
      else
      begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         fab1_r  <= fab_code_i;
         fab2_r  <= fab1_r;
      end
   end

   // ----------------------------------------------------------------
   // Strobe selection and update
   // ----------------------------------------------------------------
   logic [7:0] sel_code;
   logic       stb_edge;
   logic       stb_en;
   logic       do_update;
   logic [7:0] hold_r, hold_nxt;
   logic       upd_r, upd_nxt;

   // Data source select: fabric bus needs external arbitration
   assign sel_code = ctrl1_r[`DCL_C1_SRC] ? fab2_r : code_r;
   assign stb_en   = stb_r[`DCL_ST_EN];

   // Rising edges of synchronised strobes; bus strobe is already a pulse
   always_comb
   begin
      case (dcl_stb_src_t'(stb_r[`DCL_ST_SEL_HI:0]))
         DCL_STB_BUS:    stb_edge = bus_wr_stb;
         DCL_STB_ACLK0:  stb_edge = sync2_r[0] & ~sync3_r[0];
         DCL_STB_ACLK1:  stb_edge = sync2_r[1] & ~sync3_r[1];
         DCL_STB_ACLK2:  stb_edge = sync2_r[2] & ~sync3_r[2];
         DCL_STB_ACLK3:  stb_edge = sync2_r[3] & ~sync3_r[3];
         DCL_STB_FABRIC: stb_edge = sync2_r[4] & ~sync3_r[4];
         default:        stb_edge = 1'b0;
      endcase
   end

   // Held code follows the strobe, or tracks the source when unstrobed
   assign do_update = stb_en ? stb_edge : (hold_r != sel_code);

   always_comb
   begin
      hold_nxt = hold_r;
      upd_nxt  = 1'b0;
      if (ctrl1_r[`DCL_C1_RESET])
         hold_nxt = 8'h00;
      else if (do_update)
      begin
         // Bus strobe writes the new code in the same cycle
         hold_nxt = (stb_en && bus_wr_stb && !ctrl1_r[`DCL_C1_SRC]) ? wdata_i : sel_code;
         upd_nxt  = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hold_r <= 8'h00;
         upd_r  <= 1'b0;
      end
      else
      begin
         hold_r <= hold_nxt;
         upd_r  <= upd_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Update rate monitor: flags updates faster than the converter allows, except in the 4 V range, where the limit is capped at 63 cycles
   // ----------------------------------------------------------------
   logic [5:0] gap_r, gap_nxt;
   logic       err_r, err_nxt;
   logic [5:0] min_gap;

   // Limit depends on mode and range; the monitor only reports, never drops
   always_comb
   begin
      if (ctrl0_r[`DCL_C0_MODE])
         min_gap = 6'(`DCL_CURRENT_OUTPUT_MODE_GAP);
      else if (ctrl0_r[`DCL_C0_RANGE_LO])
         min_gap = 6'h3F;             // 4 V range, capped counter
      else
         min_gap = 6'(`DCL_VOLTAGE_OUTPUT_MODE_GAP);
      gap_nxt = (gap_r != 6'h3F) ? gap_r + 6'h01 : gap_r;
      err_nxt = err_r;
      if (upd_r)
      begin
         gap_nxt = 6'h00;
         if (gap_r < min_gap - 6'h01)
            err_nxt = 1'b1;
      end
      if (rd_i && addr_i == `DCL_ADDR_STATUS && !(upd_r && gap_r < min_gap - 6'h01))
         err_nxt = 1'b0;   // Set wins over clear on read
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         gap_r <= 6'h3F;
         err_r <= 1'b0;
      end
      else
      begin
         gap_r <= gap_nxt;
         err_r <= err_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Read port: data one cycle after the strobe
   // ----------------------------------------------------------------
   assign rdata_nxt = rd_i ? rd_mux(addr_i, {6'h00, err_r, upd_r}) : 8'h00;

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_r <= 8'h00;
      else
         rdata_r <= rdata_nxt;
   end

   // ----------------------------------------------------------------
   // Analog-side outputs
   // ----------------------------------------------------------------
   // Linear code drive; the mirrors scale it, so steps stay monotonic
   always_comb
   begin
      analog_o.code        = hold_r;
      analog_o.trim        = trim_r;
      analog_o.mode        = dcl_mode_t'(ctrl0_r[`DCL_C0_MODE]);
      analog_o.range       = ctrl0_r[`DCL_C0_RANGE_HI:`DCL_C0_RANGE_LO];
      analog_o.sink        = ctrl1_r[`DCL_C1_FAB_DIR] ? sync2_r[5]
                                                      : ctrl1_r[`DCL_C1_DIR];
      analog_o.conv_reset  = ctrl1_r[`DCL_C1_RESET];
      analog_o.route_vglob = rt0_r;
      analog_o.route_vloc  = rt2_r;
      analog_o.route_mux   = rt3_r;
   end

   assign rdata_o    = rdata_r;
   assign update_o   = upd_r;
   assign rate_err_o = err_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_strobe_cap;
      stb_en && !ctrl1_r[`DCL_C1_RESET] && stb_edge;
   endsequence

   strobe_capture_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_strobe_cap |=> upd_r)
      else $error("strobe edge did not update code");

   strobe_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (stb_en && !stb_edge && !ctrl1_r[`DCL_C1_RESET]) |=> $stable(hold_r))
      else $error("code changed without strobe");

   no_strobe_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (!stb_en && !ctrl1_r[`DCL_C1_RESET] && !wr_i) |=> (hold_r == $past(sel_code)))
      else $error("unstrobed code not applied next cycle");

   source_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ctrl1_r[`DCL_C1_SRC] |-> (sel_code == fab2_r))
      else $error("fabric source not selected");

   dir_fabric_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ctrl1_r[`DCL_C1_FAB_DIR] |-> (analog_o.sink == sync2_r[5]))
      else $error("direction not following fabric");

   dir_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !ctrl1_r[`DCL_C1_FAB_DIR] |-> (analog_o.sink == ctrl1_r[`DCL_C1_DIR]))
      else $error("direction not from register");

   mode_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_i && addr_i == `DCL_ADDR_CTRL0) |=> (analog_o.mode == $past(wdata_i[4])))
      else $error("mode bit not applied");

   trim_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_i && addr_i == `DCL_ADDR_TRIM) |=> (analog_o.trim == $past(wdata_i)))
      else $error("trim not applied");

   range_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_i && addr_i == `DCL_ADDR_CTRL0) |=> (analog_o.range == $past(wdata_i[3:2])))
      else $error("range not applied");

   rate_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (upd_r && ctrl0_r[`DCL_C0_MODE] && gap_r < 6'(`DCL_CURRENT_OUTPUT_MODE_GAP) - 6'h01) |=> err_r)
      else $error("fast update not flagged");
endmodule

// ### test/dcl_fabric_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Fabric side: code bus owner, strobe and direction lines
// ----------------------------------------------------------------
module dcl_fabric_model
(
   input  wire logic       ref_clk_i,
   output logic      [7:0] fab_code_o,
   output logic            fab_strobe_o,
   output logic            fab_sink_o,
   output logic      [3:0] aclk_o
);
   // Strobes idle low; only this model drives the shared code bus
   initial
   begin
      fab_code_o   = 8'h00;
      fab_strobe_o = 1'b0;
      fab_sink_o   = 1'b0;
      aclk_o       = 4'h0;
   end

   // One owner changes the code, so no two converters fight over it
   task automatic put_code(input logic [7:0] v);
      @(posedge ref_clk_i);
      fab_code_o <= v;
   endtask

   // Split a 12-bit value: high converter takes the top byte, low one the
   // low nibble in its middle bits, leaving its end bits for calibration
   task automatic put_split(input logic [11:0] v, input logic hi);
      if (hi)
         put_code(v[11:4]);
      else
         put_code({2'b00, v[3:0], 2'b00});
   endtask

   task automatic put_sink(input logic v);
      @(posedge ref_clk_i);
      fab_sink_o <= v;
   endtask

   // Held two cycles so the two-flop synchroniser cannot miss it
   task automatic pulse(input int idx);
      @(posedge ref_clk_i);
      if (idx < 4)
         aclk_o[idx] <= 1'b1;
      else
         fab_strobe_o <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      aclk_o       <= 4'h0;
      fab_strobe_o <= 1'b0;
   endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/1ns
`include "dcl_defs.svh"
module testbench
   import dcl_pkg::*;
;
   logic        ref_clk;
   logic        rst_n;
   logic [3:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   dcl_analog_t analog;
   logic        upd;
   logic        rerr;
   logic [7:0]  fcode;
   logic        fstb;
   logic        fsink;
   logic [3:0]  aclk;
   logic [7:0]  tmp;
   logic [7:0]  prev;
   int          err_total;
   int          cmp_count;

   dcl_control DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .fab_code_i(fcode), .fab_strobe_i(fstb),
      .fab_sink_i(fsink), .aclk_i(aclk), .analog_o(analog), .update_o(upd),
      .rate_err_o(rerr));
   dcl_fabric_model fab (.ref_clk_i(ref_clk), .fab_code_o(fcode), .fab_strobe_o(fstb),
      .fab_sink_o(fsink), .aclk_o(aclk));

   // ----------------------------------------------------------------
   // Bus tasks and checking
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd_reg(a, v);
      chk(v, e);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Synchronised sources land a few cycles later; bounded wait
   task automatic wait_upd;
      int n;
      n = 0;
      // Step past the edge that launched the request, so a stale pulse is not taken
      tick(1);
      while (upd !== 1'b1 && n < 10)
      begin
         tick(1);
         n++;
      end
      chk({7'h00, upd}, 8'h01);
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // Whole run is about 240 cycles; this is about forty times that
   initial
   begin
      #200000;
      err_total++;
      end_of_test;
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
      err_total = 0; cmp_count = 0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk(`DCL_ADDR_CTRL0, 8'h00);
      rd_chk(`DCL_ADDR_CTRL1, 8'h00);
      rd_chk(`DCL_ADDR_STROBE, 8'h00);
      rd_chk(`DCL_ADDR_CODE, 8'h00);
      rd_chk(`DCL_ADDR_TRIM, 8'h80);
      wr_reg(4'hC, 8'hFF);
      rd_chk(4'hC, 8'h00);
      wr_reg(`DCL_ADDR_TRIM, 8'h5A);
      chk(analog.trim, 8'h5A);
      rd_chk(`DCL_ADDR_TRIM, 8'h5A);
      wr_reg(`DCL_ADDR_ROUTE0, 8'hC3);
      chk(analog.route_vglob, 8'hC3);
      wr_reg(`DCL_ADDR_ROUTE2, 8'h3C);
      chk(analog.route_vloc, 8'h3C);
      wr_reg(`DCL_ADDR_ROUTE3, 8'h96);
      chk(analog.route_mux, 8'h96);
      // Every mode and range setting reaches the analog side
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(`DCL_ADDR_CTRL0, {3'h0, i[2:0], 2'b00});
         chk({7'h00, analog.mode}, {7'h00, i[2]});
         chk({6'h00, analog.range}, {6'h00, i[1:0]});
      end
      wr_reg(`DCL_ADDR_CTRL0, 8'h00);
      wr_reg(`DCL_ADDR_CODE, 8'h55);
      // Code register lands first, the held code one clock later
      tick(1);
      chk(analog.code, 8'h55);
      chk({7'h00, upd}, 8'h01);
      wr_reg(`DCL_ADDR_STROBE, 8'h08);
      wr_reg(`DCL_ADDR_CODE, 8'hA6);
      chk(analog.code, 8'hA6);
      prev = 8'hA6;
      // Pin strobes: a code write alone must not move the output
      for (int s = 1; s < 6; s++)
      begin
         wr_reg(`DCL_ADDR_STROBE, {5'h01, s[2:0]});
         wr_reg(`DCL_ADDR_CODE, 8'h10 + s[7:0]);
         tick(5);
         chk(analog.code, prev);
         fab.pulse(s - 1);
         wait_upd;
         chk(analog.code, 8'h10 + s[7:0]);
         prev = 8'h10 + s[7:0];
      end
      wr_reg(`DCL_ADDR_STROBE, 8'h00);
      fab.put_code(8'h3C);
      wr_reg(`DCL_ADDR_CTRL1, 8'h20);
      wait_upd;
      chk(analog.code, 8'h3C);
      fab.put_split(12'hC7A, 1'b1);
      wait_upd;
      chk(analog.code, 8'hC7);
      // Low converter half: low nibble lands in the middle bits
      fab.put_split(12'hC7A, 1'b0);
      wait_upd;
      chk(analog.code, 8'h28);
      wr_reg(`DCL_ADDR_CTRL1, 8'h04);
      chk({7'h00, analog.sink}, 8'h01);
      // Register bit clear, so a set sink can only come from the fabric
      wr_reg(`DCL_ADDR_CTRL1, 8'h08);
      fab.put_sink(1'b1);
      tick(5);
      chk({7'h00, analog.sink}, 8'h01);
      fab.put_sink(1'b0);
      tick(5);
      chk({7'h00, analog.sink}, 8'h00);
      wr_reg(`DCL_ADDR_CTRL1, 8'h10);
      tick(2);
      chk({7'h00, analog.conv_reset}, 8'h01);
      chk(analog.code, 8'h00);
      wr_reg(`DCL_ADDR_CTRL1, 8'h00);
      // Current mode pacing: a 7-cycle gap is the limit and legal, 4 cycles is not
      wr_reg(`DCL_ADDR_CTRL0, 8'h10);
      tick(60); // Quiet span longer than the voltage mode limit
      rd_reg(`DCL_ADDR_STATUS, tmp);
      tick(1);
      chk({7'h00, rerr}, 8'h00);
      wr_reg(`DCL_ADDR_CODE, 8'h11);
      tick(5);
      wr_reg(`DCL_ADDR_CODE, 8'h22);
      // The flag is judged one clock after the update pulse
      tick(2);
      chk({7'h00, rerr}, 8'h00);
      wr_reg(`DCL_ADDR_CODE, 8'h33);
      tick(2);
      chk({7'h00, rerr}, 8'h01);
      rd_reg(`DCL_ADDR_STATUS, tmp);
      chk(tmp, 8'h02);
      tick(1);
      chk({7'h00, rerr}, 8'h00);
      end_of_test;
   end
endmodule
